// [gpio_cfg_device.sv]
// GPIO logical device behind an index/data configuration port pair
// Function
// - Direction bit one is input, resets ones
// - Output pin data bits read/write, reset zero
// - Input pin data bits read pin, unwritable
// - Polarity bit inverts both directions, resets zero
// - Index port write-only at 2Eh or 4Eh
// - Data port read/write at 2Fh or 4Fh
// - Two successive 87h index writes unlock
// - Index 07h, value 07h selects GPIO device
// - Indices F0/F1/F2 reach direction, data, polarity
// - AAh to index relocks until new key
`timescale 1ns/10ps
`include "cfg_defs.svh"
module gpio_cfg_device (
	// Clock and reset
	input  wire logic  ref_clk,
	input  wire logic  sys_rst,
	// Port base select, high picks 4Eh/4Fh
	input  wire logic  use_alt_base,
	// Host I/O cycles
	cfg_io_if.device   io,
	// GPIO pins
	input  wire logic [7:0] pin_in,
	output logic [7:0]      pin_out,
	output logic [7:0]      pin_oe
);
	import cfg_pkg::*;

	logic [7:0] pin_meta_r;
	logic [7:0] pin_sync_r;
	logic       unlocked_r;
	logic       unlocked_nxt;
	logic       key_seen_r;
	logic       key_seen_nxt;
	logic [7:0] index_r;
	logic [7:0] index_nxt;
	logic [7:0] ldn_r;
	logic [7:0] ldn_nxt;
	logic [7:0] dir_r;
	logic [7:0] dir_nxt;
	logic [7:0] data_r;
	logic [7:0] data_nxt;
	logic [7:0] pol_r;
	logic [7:0] pol_nxt;
	logic [7:0] drive_r;
	logic [7:0] drive_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       ack_r;
	logic       ack_nxt;
	logic       hit_index;
	logic       hit_data;
	logic       gpio_sel;
	logic [7:0] pin_view;
	logic [7:0] cfg_rd;
	logic [7:0] pin_meta_nxt;
	logic [7:0] pin_sync_nxt;
	logic [7:0] data_rd_bits;
	logic [7:0] data_wr_bits;

	// Pin synchroniser, second stage only is read
	always_comb begin
		pin_meta_nxt = pin_in;
		pin_sync_nxt = pin_meta_r;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pin_meta_r <= `BYTE_ZERO;
			pin_sync_r <= `BYTE_ZERO;
		end else begin
			pin_meta_r <= pin_meta_nxt;
			pin_sync_r <= pin_sync_nxt;
		end
	end

	always_comb begin
		hit_index = 1'b0;
		hit_data  = 1'b0;
		if (use_alt_base) begin
			hit_index = (io.io_addr == `IDX_PORT_ALT);
			hit_data  = (io.io_addr == `DATA_PORT_ALT);
		end else begin
			hit_index = (io.io_addr == `IDX_PORT_BASE);
			hit_data  = (io.io_addr == `DATA_PORT_BASE);
		end
	end

	assign gpio_sel = (ldn_r == `LDN_GPIO);

	// Pin level as seen through the polarity register
	assign pin_view = pin_sync_r ^ pol_r;

	// Per-pin data bit: stored value for outputs, pin level for inputs
	for (genvar g = 0; g < $bits(dir_r); g++) begin : pin_bit_g
		assign data_rd_bits[g] = dir_r[g] ? pin_view[g] : data_r[g];
		assign data_wr_bits[g] = dir_r[g] ? data_r[g] : io.io_wdata[g];
	end

	// Configuration register read mux
	always_comb begin
		cfg_rd = `BYTE_ZERO;
		if (index_r == `IDX_LDN) begin
			cfg_rd = ldn_r;
		end else if (gpio_sel && index_r == `IDX_DIR) begin
			cfg_rd = dir_r;
		end else if (gpio_sel && index_r == `IDX_DATA) begin
			cfg_rd = data_rd_bits;
		end else if (gpio_sel && index_r == `IDX_POL) begin
			cfg_rd = pol_r;
		end
	end

	// Key sequence and index register
	always_comb begin
		unlocked_nxt = unlocked_r;
		key_seen_nxt = key_seen_r;
		index_nxt    = index_r;
		if (io.io_wr && hit_index) begin
			if (!unlocked_r) begin
				if (io.io_wdata == `KEY_ENTER) begin
					// Second key in a row opens the port
					unlocked_nxt = key_seen_r;
					key_seen_nxt = !key_seen_r;
				end else begin
					key_seen_nxt = 1'b0;
				end
			end else if (io.io_wdata == `KEY_EXIT) begin
				unlocked_nxt = 1'b0;
				key_seen_nxt = 1'b0;
			end else begin
				index_nxt = io.io_wdata;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			unlocked_r <= 1'b0;
			key_seen_r <= 1'b0;
			index_r    <= `IDX_RST;
		end else begin
			unlocked_r <= unlocked_nxt;
			key_seen_r <= key_seen_nxt;
			index_r    <= index_nxt;
		end
	end

	// Configuration registers behind the data port
	always_comb begin
		ldn_nxt  = ldn_r;
		dir_nxt  = dir_r;
		data_nxt = data_r;
		pol_nxt  = pol_r;
		if (io.io_wr && hit_data && unlocked_r) begin
			if (index_r == `IDX_LDN) begin
				ldn_nxt = io.io_wdata;
			end else if (gpio_sel && index_r == `IDX_DIR) begin
				dir_nxt = io.io_wdata;
			end else if (gpio_sel && index_r == `IDX_DATA) begin
				// Input bits keep their stored value
				data_nxt = data_wr_bits;
			end else if (gpio_sel && index_r == `IDX_POL) begin
				pol_nxt = io.io_wdata;
			end
		end
		drive_nxt = data_nxt ^ pol_nxt;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ldn_r   <= `LDN_RST;
			dir_r   <= `DIR_RST;
			data_r  <= `DATA_RST;
			pol_r   <= `POL_RST;
			drive_r <= `DATA_RST;
		end else begin
			ldn_r   <= ldn_nxt;
			dir_r   <= dir_nxt;
			data_r  <= data_nxt;
			pol_r   <= pol_nxt;
			drive_r <= drive_nxt;
		end
	end

	// Host cycle answer
	always_comb begin
		ack_nxt   = io.io_wr | io.io_rd;
		rdata_nxt = rdata_r;
		if (io.io_rd) begin
			if (hit_data && unlocked_r) begin
				rdata_nxt = cfg_rd;
			end else begin
				// Index port and locked data port float high
				rdata_nxt = `BYTE_ONES;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdata_r <= `BYTE_ONES;
			ack_r   <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			ack_r   <= ack_nxt;
		end
	end

	assign pin_out     = drive_r;
	assign pin_oe      = ~dir_r;
	assign io.io_rdata = rdata_r;
	assign io.io_ack   = ack_r;

endmodule

// [cfg_defs.svh]
// Constants for the indexed configuration GPIO port and its host controller
`ifndef CFG_DEFS_SVH
`define CFG_DEFS_SVH

`define IDX_PORT_BASE   16'h002E
`define IDX_PORT_ALT    16'h004E
`define DATA_PORT_BASE  16'h002F
`define DATA_PORT_ALT   16'h004F

`define KEY_ENTER       8'h87
`define KEY_EXIT        8'hAA
`define IDX_LDN         8'h07
`define LDN_GPIO        8'h07
`define IDX_DIR         8'hF0
`define IDX_DATA        8'hF1
`define IDX_POL         8'hF2

`define DIR_RST         8'hFF
`define DATA_RST        8'h00
`define POL_RST         8'h00
`define IDX_RST         8'h00
`define LDN_RST         8'h00
`define BYTE_ZERO       8'h00
`define BYTE_ONES       8'hFF
`define PORT_IDLE       16'h0000

`define APB_CMD         8'h00
`define APB_STATUS      8'h04
`define APB_CONFIG      8'h08
`define CMD_OP_LSB      0
`define CMD_OP_MSB      1
`define CMD_IDX_LSB     8
`define CMD_IDX_MSB     15
`define CMD_VAL_LSB     16
`define CMD_VAL_MSB     23
`define STAT_BUSY       0
`define STAT_RD_LSB     8
`define STAT_RD_MSB     15
`define CONF_ALT        0
`define STEP_RST        2'h0
`define STEP_LDN_SEL    2'h1
`define STEP_IDX        2'h2
`define STEP_DATA       2'h3

`endif

// [cfg_pkg.sv]
// Types shared by the configuration port device and host
package cfg_pkg;

	typedef enum logic [1:0] {
		OP_UNLOCK,
		OP_LOCK,
		OP_WRITE,
		OP_READ
	} host_op_t;

	typedef enum logic [1:0] {
		H_IDLE,
		H_ISSUE,
		H_WAIT
	} host_state_t;

	typedef struct packed {
		logic       wr;
		logic       data_port;
		logic [7:0] val;
		logic       last;
	} step_t;

endpackage

// [cfg_io_if.sv]
// Host I/O cycle carrier between configuration controller and GPIO device
`timescale 1ns/10ps
interface cfg_io_if;
	logic [15:0] io_addr;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_wdata;
	logic [7:0]  io_rdata;
	logic        io_ack;

	modport device (
		input  io_addr,
		input  io_wr,
		input  io_rd,
		input  io_wdata,
		output io_rdata,
		output io_ack
	);

	modport host (
		output io_addr,
		output io_wr,
		output io_rd,
		output io_wdata,
		input  io_rdata,
		input  io_ack
	);
endinterface

// [gpio_cfg_host.sv]
// Host controller driving configuration port sequences from APB commands
`timescale 1ns/10ps
`include "cfg_defs.svh"
module gpio_cfg_host (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Configuration port cycles
	cfg_io_if.host           io
);
	import cfg_pkg::*;

	host_state_t state_r;
	host_state_t state_nxt;
	host_op_t    op_r;
	host_op_t    op_nxt;
	logic [7:0]  idx_r;
	logic [7:0]  idx_nxt;
	logic [7:0]  val_r;
	logic [7:0]  val_nxt;
	logic [1:0]  step_r;
	logic [1:0]  step_nxt;
	logic [7:0]  rd_r;
	logic [7:0]  rd_nxt;
	logic        alt_r;
	logic        alt_nxt;
	logic        wr_r;
	logic        wr_nxt;
	logic        rd_req_r;
	logic        rd_req_nxt;
	logic [15:0] addr_r;
	logic [15:0] addr_nxt;
	logic [7:0]  wdata_r;
	logic [7:0]  wdata_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        mapped;
	logic        cmd_wr;
	step_t       cur;

	assign mapped = (paddr[7:0] == `APB_CMD) || (paddr[7:0] == `APB_STATUS)
		|| (paddr[7:0] == `APB_CONFIG);
	assign cmd_wr = psel && penable && pwrite && (paddr[7:0] == `APB_CMD);

	// Current bus cycle of the running sequence
	always_comb begin
		cur = '{wr: 1'b1, data_port: 1'b0, val: `KEY_ENTER, last: 1'b0};
		if (op_r == OP_UNLOCK) begin
			cur.last = (step_r != `STEP_RST);
		end else if (op_r == OP_LOCK) begin
			cur.val  = `KEY_EXIT;
			cur.last = 1'b1;
		end else if (step_r == `STEP_RST) begin
			cur.val = `IDX_LDN;
		end else if (step_r == `STEP_LDN_SEL) begin
			cur.data_port = 1'b1;
			cur.val       = `LDN_GPIO;
		end else if (step_r == `STEP_IDX) begin
			cur.val = idx_r;
		end else begin
			cur.data_port = 1'b1;
			cur.val       = val_r;
			cur.wr        = (op_r == OP_WRITE);
			cur.last      = 1'b1;
		end
	end

	always_comb begin
		state_nxt  = state_r;
		op_nxt     = op_r;
		idx_nxt    = idx_r;
		val_nxt    = val_r;
		step_nxt   = step_r;
		rd_nxt     = rd_r;
		alt_nxt    = alt_r;
		wr_nxt     = 1'b0;
		rd_req_nxt = 1'b0;
		addr_nxt   = addr_r;
		wdata_nxt  = wdata_r;
		prdata_nxt = prdata_r;
		if (psel && !penable) begin
			prdata_nxt = 32'h0000_0000;
			if (paddr[7:0] == `APB_STATUS) begin
				prdata_nxt[`STAT_BUSY] = (state_r != H_IDLE);
				prdata_nxt[`STAT_RD_MSB:`STAT_RD_LSB] = rd_r;
			end else if (paddr[7:0] == `APB_CONFIG) begin
				prdata_nxt[`CONF_ALT] = alt_r;
			end
		end
		if (psel && penable && pwrite && paddr[7:0] == `APB_CONFIG) begin
			alt_nxt = pwdata[`CONF_ALT];
		end
		case (state_r)
			H_IDLE: begin
				if (cmd_wr) begin
					op_nxt    = host_op_t'(pwdata[`CMD_OP_MSB:`CMD_OP_LSB]);
					idx_nxt   = pwdata[`CMD_IDX_MSB:`CMD_IDX_LSB];
					val_nxt   = pwdata[`CMD_VAL_MSB:`CMD_VAL_LSB];
					step_nxt  = `STEP_RST;
					state_nxt = H_ISSUE;
				end
			end
			H_ISSUE: begin
				wr_nxt     = cur.wr;
				rd_req_nxt = !cur.wr;
				wdata_nxt  = cur.val;
				if (cur.data_port) begin
					addr_nxt = alt_r ? `DATA_PORT_ALT : `DATA_PORT_BASE;
				end else begin
					addr_nxt = alt_r ? `IDX_PORT_ALT : `IDX_PORT_BASE;
				end
				state_nxt = H_WAIT;
			end
			H_WAIT: begin
				if (io.io_ack) begin
					if (!cur.wr) begin
						rd_nxt = io.io_rdata;
					end
					if (cur.last) begin
						state_nxt = H_IDLE;
					end else begin
						step_nxt  = step_r + 2'h1;
						state_nxt = H_ISSUE;
					end
				end
			end
			default: begin
				state_nxt = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_r  <= H_IDLE;
			op_r     <= OP_UNLOCK;
			idx_r    <= `IDX_RST;
			val_r    <= `BYTE_ZERO;
			step_r   <= `STEP_RST;
			rd_r     <= `BYTE_ZERO;
			alt_r    <= 1'b0;
			wr_r     <= 1'b0;
			rd_req_r <= 1'b0;
			addr_r   <= `PORT_IDLE;
			wdata_r  <= `BYTE_ZERO;
			prdata_r <= 32'h0000_0000;
		end else begin
			state_r  <= state_nxt;
			op_r     <= op_nxt;
			idx_r    <= idx_nxt;
			val_r    <= val_nxt;
			step_r   <= step_nxt;
			rd_r     <= rd_nxt;
			alt_r    <= alt_nxt;
			wr_r     <= wr_nxt;
			rd_req_r <= rd_req_nxt;
			addr_r   <= addr_nxt;
			wdata_r  <= wdata_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	assign io.io_wr    = wr_r;
	assign io.io_rd    = rd_req_r;
	assign io.io_addr  = addr_r;
	assign io.io_wdata = wdata_r;
	assign prdata      = prdata_r;
	assign pready      = 1'b1;
	assign pslverr     = psel && penable && !mapped;

endmodule

// [gpio_port_chk.sv]
// Checker for host I/O cycles between the configuration host and GPIO device
`timescale 1ns/10ps
`include "cfg_defs.svh"
module gpio_port_chk (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// Host I/O cycles
	input wire logic [15:0] io_addr,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic [7:0]  io_wdata,
	input wire logic [7:0]  io_rdata,
	input wire logic        io_ack
);
	logic lk_r;
	logic k_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// Lock state as seen from index-port writes
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lk_r <= 1'b1;
			k_r  <= 1'b0;
		end else if (io_wr && !io_addr[0]) begin
			k_r <= io_wdata == `KEY_ENTER;
			if (k_r && io_wdata == `KEY_ENTER)
				lk_r <= 1'b0;
			if (io_wdata == `KEY_EXIT)
				lk_r <= 1'b1;
		end
	end

	ack_after_a: assert property ((io_wr || io_rd) |=> io_ack)
		else $error("no ack after cycle");
	ack_cause_a: assert property (io_ack |-> $past(io_wr || io_rd))
		else $error("ack without cycle");
	cyc_excl_a: assert property (!(io_wr && io_rd))
		else $error("read and write together");
	port_ok_a: assert property ((io_wr || io_rd) |-> io_addr inside {`IDX_PORT_BASE,
		`IDX_PORT_ALT, `DATA_PORT_BASE, `DATA_PORT_ALT}) else $error("bad port address");
	no_idx_rd_a: assert property (io_rd |-> io_addr[0])
		else $error("index port read");
	locked_rd_a: assert property (io_rd && lk_r |=> io_rdata == `BYTE_ONES)
		else $error("locked read not FF");
	rst_idle_a: assert property ($past(sys_rst) |-> !io_ack && io_rdata == `BYTE_ONES)
		else $error("bad state after reset");
	rdata_hold_a: assert property (!io_rd |=> $stable(io_rdata))
		else $error("read data moved");
	req_hold_a: assert property (io_ack |-> $stable(io_addr) && $stable(io_wdata))
		else $error("request not held");
endmodule

// [tb_top.sv]
// Testbench for the APB configuration host driving the GPIO device
`timescale 1ns/10ps
`include "cfg_defs.svh"
module tb_top;
	logic        ref_clk, sys_rst, alt, psel, penable, pwrite, mark, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rv;
	logic [7:0]  ext, pin, pin_out, pin_oe, v, p, m;
	logic [8:0]  q[$];
	int          failures, n_checks, cyc;

	cfg_io_if io();
	gpio_cfg_device gpio_cfg_device_i (.ref_clk, .sys_rst, .use_alt_base(alt), .io(io),
		.pin_in(pin), .pin_out, .pin_oe);
	gpio_cfg_host gpio_cfg_host_i (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .io(io));
	gpio_port_chk gpio_port_chk_i (.ref_clk, .sys_rst, .io_addr(io.io_addr),
		.io_wr(io.io_wr), .io_rd(io.io_rd), .io_wdata(io.io_wdata),
		.io_rdata(io.io_rdata), .io_ack(io.io_ack));
	// Pin wire: driven bits follow the device, others the outside
	assign pin = (pin_oe & pin_out) | (~pin_oe & ext);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task chk(input logic [8:0] s, input logic [8:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask

	task test_done;
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		if (psel && penable && pready && mark)
			chk({pslverr, pslverr ? 8'h00 : prdata[15:8]}, q.pop_front());
		cyc++;
		if (cyc == 30000) begin
			failures++;
			test_done;
		end
	end

	task apb(input logic w, input logic mk, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		mark    <= mk;
		paddr   <= {24'h000000, a};
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (!pready);
		rv = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		mark    <= 1'b0;
	endtask

	task cmd(input logic [1:0] op, input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, 1'b0, `APB_CMD, {8'h00, d, i, 6'h00, op});
		do apb(1'b0, 1'b0, `APB_STATUS, 32'h0); while (rv[`STAT_BUSY] !== 1'b0);
	endtask

	task rd(input logic [7:0] i, input logic [7:0] e);
		cmd(2'h3, i, 8'h00);
		q.push_back({1'b0, e});
		apb(1'b0, 1'b1, `APB_STATUS, 32'h0);
	endtask

	task pins(input logic [7:0] oe, input logic [7:0] o);
		chk({1'b0, pin_oe}, {1'b0, oe});
		chk({1'b0, pin_out}, {1'b0, o});
	endtask

	initial begin
		{sys_rst, psel, penable, pwrite, mark, alt} = 6'h20;
		{paddr, pwdata, ext, v, p, m} = '0;
		{failures, n_checks, cyc} = '0;
		void'($urandom(69));
		for (int a = 0; a < 2; a++) begin
			sys_rst <= 1'b1;
			repeat (10) @(posedge ref_clk);
			sys_rst <= 1'b0;
			alt     <= a[0];
			ext     <= 8'($urandom);
			v = 8'($urandom);
			p = 8'($urandom);
			m = 8'($urandom);
			apb(1'b1, 1'b0, `APB_CONFIG, 32'(a));
			rd(`IDX_DATA, 8'hFF);
			cmd(2'h2, `IDX_DIR, 8'h00);
			cmd(2'h0, 8'h00, 8'h00);
			rd(`IDX_DIR, `DIR_RST);
			rd(`IDX_POL, `POL_RST);
			rd(`IDX_LDN, `LDN_GPIO);
			pins(8'h00, 8'h00);
			rd(`IDX_DATA, ext);
			cmd(2'h2, `IDX_DIR, 8'h00);
			cmd(2'h2, `IDX_DATA, v);
			pins(8'hFF, v);
			cmd(2'h2, `IDX_POL, p);
			pins(8'hFF, v ^ p);
			rd(`IDX_DATA, v);
			cmd(2'h2, `IDX_DIR, m);
			rd(`IDX_DATA, ~m & v | m & (ext ^ p));
			cmd(2'h2, `IDX_DATA, ~v);
			rd(`IDX_DATA, ~m & ~v | m & (ext ^ p));
			cmd(2'h1, 8'h00, 8'h00);
			cmd(2'h2, `IDX_DIR, 8'h00);
			rd(`IDX_DIR, 8'hFF);
			cmd(2'h0, 8'h00, 8'h00);
			rd(`IDX_DIR, m);
			cmd(2'h2, `IDX_DIR, 8'h00);
			pins(8'hFF, (~m & ~v | m & v) ^ p);
		end
		q.push_back(9'h100);
		apb(1'b0, 1'b1, 8'h0C, 32'h0);
		test_done;
	end
endmodule
